/* File: common/smu_pkg.sv */
// constants shared by the signal mixer unit and its stream buffer
package smu_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  // register indexes, byte address is four times the index
  localparam logic [13:0] IDX_CON0   = 14'h0F51;
  localparam logic [13:0] IDX_CON1   = 14'h0F52;
  localparam logic [13:0] IDX_SRC    = 14'h0F53;
  localparam logic [13:0] IDX_LCAR   = 14'h0F54;
  localparam logic [13:0] IDX_HCAR   = 14'h0F55;
  localparam logic [13:0] IDX_STREAM = 14'h0F56;
  localparam logic [13:0] IDX_RATE   = 14'h0F57;
  // control field positions
  localparam int unsigned CON0_EN     = 7;
  localparam int unsigned CON0_OUT    = 5;
  localparam int unsigned CON0_OINV   = 4;
  localparam int unsigned CON0_BIT    = 0;
  localparam int unsigned CON1_HINV   = 5;
  localparam int unsigned CON1_HSYNC  = 4;
  localparam int unsigned CON1_LINV   = 1;
  localparam int unsigned CON1_LSYNC  = 0;
  localparam int unsigned STR_ACTIVE  = 8;
  // reset values
  localparam logic [3:0]  RST_SRC  = 4'h0;
  localparam logic [2:0]  RST_CAR  = 3'h0;
  localparam logic [15:0] RST_RATE = 16'h0000;
  // modulator source codes
  localparam logic [3:0] MSRC_PIN  = 4'h0;
  localparam logic [3:0] MSRC_SW   = 4'h1;
  localparam logic [3:0] MSRC_CC1  = 4'h2;
  localparam logic [3:0] MSRC_CC2  = 4'h3;
  localparam logic [3:0] MSRC_PW3  = 4'h4;
  localparam logic [3:0] MSRC_PW4  = 4'h5;
  localparam logic [3:0] MSRC_COMPARATOR_ONE_OUT = 4'h6;
  localparam logic [3:0] MSRC_COMPARATOR_TWO_OUT = 4'h7;
  localparam logic [3:0] MSRC_RX   = 4'h8;
  localparam logic [3:0] MSRC_TX   = 4'h9;
  localparam logic [3:0] MSRC_SDO  = 4'hA;
  // carrier source codes
  localparam logic [2:0] CSRC_PIN  = 3'h0;
  localparam logic [2:0] CSRC_SYS  = 3'h1;
  localparam logic [2:0] CSRC_FAST = 3'h2;
  localparam logic [2:0] CSRC_REF  = 3'h3;
  localparam logic [2:0] CSRC_CC1  = 3'h4;
  localparam logic [2:0] CSRC_CC2  = 3'h5;
  localparam logic [2:0] CSRC_PW3  = 3'h6;
  localparam logic [2:0] CSRC_PW4  = 3'h7;
  // stream buffer shape and pin synchroniser count
  localparam int unsigned FIFO_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LVL_W      = 5;
  localparam int unsigned SYNC_N     = 5;
  typedef enum logic {APB_IDLE, APB_DONE} smu_apb_state_type;
endpackage

/* File: verilog/smu_fifo.sv */
// flip-flop fifo with valid/ready on both sides
module smu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [WIDTH-1:0]           i_in_data,
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [WIDTH-1:0]                o_out_data,
  output logic [$clog2(DEPTH):0]          o_level
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign o_level     = cnt_q;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  AST_NO_OVERFLOW:
    assert property (@(posedge i_clk) disable iff (i_rst)
      cnt_q == (AW+1)'(DEPTH) && !pop |=> cnt_q == (AW+1)'(DEPTH))
    else $error("fifo level moved while full without a pop");
endmodule

/* File: verilog/smu_signal_mixer_unit.sv */
// signal mixer unit: apb registers, source muxes, carrier sync, stream feed
// Function
// - output is selected carrier gated by the modulator level
// - modulator high mixes the high carrier
// - modulator low mixes the low carrier
// - setting enable starts modulation
// - clearing enable keeps all source selections
// - re-enabling resumes with retained selections
// - output pin is low while disabled
// - 4-bit field picks the modulator source
// - 3-bit field picks the high carrier source
// - low carrier field uses same encoding, own pin at code zero
// - sources come from peripherals or from pins
// - output is a plain pin signal for output routing
// - high carrier sync delays switch to low until its falling edge
// - low carrier sync delays switch to high until its falling edge
// - carrier invert bits flip each carrier before mixing
// - output invert bit flips the mixed output
//
// The APB register port and the placing of the registers were left to the implementer.
module smu_signal_mixer_unit (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_modulator_pin_route,
  input  wire logic        i_high_carrier_pin_route,
  input  wire logic        i_low_carrier_pin_route,
  input  wire logic        i_fast_internal_oscillator,
  input  wire logic        i_reference_clock_output,
  input  wire logic        i_capture_compare_one_out,
  input  wire logic        i_capture_compare_two_out,
  input  wire logic        i_pulse_width_three_out,
  input  wire logic        i_pulse_width_four_out,
  input  wire logic        i_comparator_one_out,
  input  wire logic        i_comparator_two_out,
  input  wire logic        i_async_serial_port_rx,
  input  wire logic        i_async_serial_port_tx,
  input  wire logic        i_sync_serial_port_sdo,
  output logic             o_modulated_output_pin
);
  localparam int unsigned LW = smu_pkg::LVL_W;

  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [13:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  function automatic logic carrier_pick(input logic [2:0] sel,
                                        input logic       pin,
                                        input logic       sys,
                                        input logic       fast,
                                        input logic       refc);
    case (sel)
      smu_pkg::CSRC_PIN:  carrier_pick = pin;
      smu_pkg::CSRC_SYS:  carrier_pick = sys;
      smu_pkg::CSRC_FAST: carrier_pick = fast;
      smu_pkg::CSRC_REF:  carrier_pick = refc;
      smu_pkg::CSRC_CC1:  carrier_pick = i_capture_compare_one_out;
      smu_pkg::CSRC_CC2:  carrier_pick = i_capture_compare_two_out;
      smu_pkg::CSRC_PW3:  carrier_pick = i_pulse_width_three_out;
      smu_pkg::CSRC_PW4:  carrier_pick = i_pulse_width_four_out;
      default:            carrier_pick = 1'b0;
    endcase
  endfunction

  // ---- pin synchronisers: three stages, change accepted on agreement
  logic [smu_pkg::SYNC_N-1:0] async_in;
  logic [smu_pkg::SYNC_N-1:0] pin_v;
  assign async_in = {i_reference_clock_output, i_fast_internal_oscillator,
                     i_low_carrier_pin_route, i_high_carrier_pin_route,
                     i_modulator_pin_route};

  for (genvar g = 0; g < smu_pkg::SYNC_N; g++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic v_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        v_q  <= 1'b0;
      end else begin
        s1_q <= async_in[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          v_q <= s3_q;
        end
      end
    end
    assign pin_v[g] = v_q;
  end

  // ---- registers
  logic        en_q;
  logic        oinv_q;
  logic        bit_q;
  logic        hinv_q;
  logic        hsync_q;
  logic        linv_q;
  logic        lsync_q;
  logic [3:0]  src_q;
  logic [2:0]  lsel_q;
  logic [2:0]  hsel_q;
  logic [15:0] rate_q;
  logic        out_q;
  smu_pkg::smu_apb_state_type st_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // ---- apb decode
  logic        acc;
  logic        hit_con0;
  logic        hit_con1;
  logic        hit_src;
  logic        hit_lcar;
  logic        hit_hcar;
  logic        hit_stream;
  logic        hit_rate;
  logic        mapped;
  logic        stall;
  logic        commit;
  logic        wr;
  logic [31:0] rd_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic        stream_active;

  assign acc        = i_psel & i_penable;
  assign hit_con0   = reg_hit(i_paddr, smu_pkg::IDX_CON0);
  assign hit_con1   = reg_hit(i_paddr, smu_pkg::IDX_CON1);
  assign hit_src    = reg_hit(i_paddr, smu_pkg::IDX_SRC);
  assign hit_lcar   = reg_hit(i_paddr, smu_pkg::IDX_LCAR);
  assign hit_hcar   = reg_hit(i_paddr, smu_pkg::IDX_HCAR);
  assign hit_stream = reg_hit(i_paddr, smu_pkg::IDX_STREAM);
  assign hit_rate   = reg_hit(i_paddr, smu_pkg::IDX_RATE);
  assign mapped     = hit_con0 | hit_con1 | hit_src | hit_lcar | hit_hcar
                    | hit_stream | hit_rate;
  // a stream write waits in the access phase until the buffer has room
  assign stall      = hit_stream & i_pwrite & ~fifo_in_ready;
  assign commit     = acc & (st_q == smu_pkg::APB_DONE);
  assign wr         = commit & i_pwrite & mapped;

  assign rd_data =
    hit_con0 ? {24'h0000_00, en_q, 1'b0, out_q, oinv_q, 3'h0, bit_q} :
    hit_con1 ? {24'h0000_00, 2'h0, hinv_q, hsync_q, 2'h0, linv_q,
                lsync_q} :
    hit_src  ? {28'h000_0000, src_q} :
    hit_lcar ? {29'h0000_0000, lsel_q} :
    hit_hcar ? {29'h0000_0000, hsel_q} :
    hit_stream ? {23'h00_0000, stream_active, 3'h0, fifo_level} :
    hit_rate ? {16'h0000, rate_q} : 32'h0000_0000;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q      <= smu_pkg::APB_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (st_q == smu_pkg::APB_IDLE) begin
      if (acc && !stall) begin
        st_q      <= smu_pkg::APB_DONE;
        pready_q  <= 1'b1;
        pslverr_q <= ~mapped;
        prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_data;
      end
    end else begin
      st_q      <= smu_pkg::APB_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_q     <= 1'b0;
      oinv_q   <= 1'b0;
      bit_q    <= 1'b0;
      hinv_q   <= 1'b0;
      hsync_q  <= 1'b0;
      linv_q   <= 1'b0;
      lsync_q  <= 1'b0;
      src_q    <= smu_pkg::RST_SRC;
      lsel_q   <= smu_pkg::RST_CAR;
      hsel_q   <= smu_pkg::RST_CAR;
      rate_q   <= smu_pkg::RST_RATE;
    end else if (wr) begin
      if (hit_con0) begin
        en_q   <= i_pwdata[smu_pkg::CON0_EN];
        oinv_q <= i_pwdata[smu_pkg::CON0_OINV];
        bit_q  <= i_pwdata[smu_pkg::CON0_BIT];
      end
      if (hit_con1) begin
        hinv_q  <= i_pwdata[smu_pkg::CON1_HINV];
        hsync_q <= i_pwdata[smu_pkg::CON1_HSYNC];
        linv_q  <= i_pwdata[smu_pkg::CON1_LINV];
        lsync_q <= i_pwdata[smu_pkg::CON1_LSYNC];
      end
      // selections only change by their own writes
      if (hit_src) begin
        src_q <= i_pwdata[3:0];
      end
      if (hit_lcar) begin
        lsel_q <= i_pwdata[2:0];
      end
      if (hit_hcar) begin
        hsel_q <= i_pwdata[2:0];
      end
      if (hit_rate) begin
        rate_q <= i_pwdata[15:0];
      end
    end
  end

  // ---- software bit stream: bytes shifted out lsb first per rate tick
  logic [15:0] div_q;
  logic        tick;
  logic [7:0]  shift_q;
  logic [3:0]  left_q;
  logic        drain_on;
  logic        pop;
  logic        sw_bit;

  assign tick          = (div_q == rate_q);
  assign drain_on      = en_q & (src_q == smu_pkg::MSRC_SW);
  assign pop           = tick & drain_on & (left_q <= 4'h1) & fifo_out_valid;
  assign stream_active = (left_q != 4'h0);
  // the buffered stream overrides the static bit while it has data
  assign sw_bit        = stream_active ? shift_q[0] : bit_q;

  smu_fifo #(
    .WIDTH (smu_pkg::FIFO_W),
    .DEPTH (smu_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (wr & hit_stream),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_pwdata[7:0]),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_out_data),
    .o_level     (fifo_level)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q   <= 16'h0000;
      shift_q <= 8'h00;
      left_q  <= 4'h0;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      if (pop) begin
        shift_q <= fifo_out_data;
        left_q  <= 4'h8;
      end else if (tick && drain_on && left_q != 4'h0) begin
        shift_q <= {1'b0, shift_q[7:1]};
        left_q  <= left_q - 4'h1;
      end
    end
  end

  // ---- source selection and mixing
  logic sys_q;
  logic modv;
  logic hcar;
  logic lcar;
  logic carrier_high_prev_q;
  logic carrier_low_prev_q;
  logic hfall;
  logic lfall;
  logic go_low;
  logic go_high;
  logic sel_high_q;
  logic sel_high_d;
  logic mix_w;

  assign modv =
    (src_q == smu_pkg::MSRC_PIN)  ? pin_v[0] :
    (src_q == smu_pkg::MSRC_SW)   ? sw_bit :
    (src_q == smu_pkg::MSRC_CC1)  ? i_capture_compare_one_out :
    (src_q == smu_pkg::MSRC_CC2)  ? i_capture_compare_two_out :
    (src_q == smu_pkg::MSRC_PW3)  ? i_pulse_width_three_out :
    (src_q == smu_pkg::MSRC_PW4)  ? i_pulse_width_four_out :
    (src_q == smu_pkg::MSRC_COMPARATOR_ONE_OUT) ? i_comparator_one_out :
    (src_q == smu_pkg::MSRC_COMPARATOR_TWO_OUT) ? i_comparator_two_out :
    (src_q == smu_pkg::MSRC_RX)   ? i_async_serial_port_rx :
    (src_q == smu_pkg::MSRC_TX)   ? i_async_serial_port_tx :
    (src_q == smu_pkg::MSRC_SDO)  ? i_sync_serial_port_sdo : 1'b0;

  assign hcar = carrier_pick(hsel_q, pin_v[1], sys_q, pin_v[3], pin_v[4])
              ^ hinv_q;
  assign lcar = carrier_pick(lsel_q, pin_v[2], sys_q, pin_v[3], pin_v[4])
              ^ linv_q;

  assign hfall = carrier_high_prev_q & ~hcar;
  assign lfall = carrier_low_prev_q & ~lcar;
  assign go_low  = sel_high_q & ~modv & (~hsync_q | hfall);
  assign go_high = ~sel_high_q & modv & (~lsync_q | lfall);
  assign sel_high_d = go_low ? 1'b0 : (go_high ? 1'b1 : sel_high_q);
  assign mix_w = sel_high_d ? hcar : lcar;

  // the system clock carrier can only be shown at half rate here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sys_q       <= 1'b0;
      carrier_high_prev_q <= 1'b0;
      carrier_low_prev_q <= 1'b0;
      sel_high_q  <= 1'b0;
      out_q       <= 1'b0;
    end else begin
      sys_q       <= ~sys_q;
      carrier_high_prev_q <= hcar;
      carrier_low_prev_q <= lcar;
      sel_high_q  <= sel_high_d;
      out_q       <= en_q & (mix_w ^ oinv_q);
    end
  end

  assign o_modulated_output_pin = out_q;
  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;

  AST_OFF_LOW:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !en_q |=> !o_modulated_output_pin)
    else $error("output not low while disabled");
  AST_HIGH_PATH:
    assert property (@(posedge i_clk) disable iff (i_rst)
      en_q && !oinv_q && modv && !sel_high_q && !lsync_q
      |=> o_modulated_output_pin == $past(hcar))
    else $error("high carrier not mixed while modulator high");
  AST_LOW_PATH:
    assert property (@(posedge i_clk) disable iff (i_rst)
      en_q && !oinv_q && !modv && sel_high_q && !hsync_q
      |=> o_modulated_output_pin == $past(lcar))
    else $error("low carrier not mixed while modulator low");
  AST_INVERT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      en_q && oinv_q |=> o_modulated_output_pin != $past(mix_w))
    else $error("output not inverted");
  AST_HOLD_HIGH:
    assert property (@(posedge i_clk) disable iff (i_rst)
      sel_high_q && hsync_q && !hfall |=> sel_high_q)
    else $error("left high carrier before its falling edge");
  AST_HOLD_LOW:
    assert property (@(posedge i_clk) disable iff (i_rst)
      !sel_high_q && lsync_q && !lfall |=> !sel_high_q)
    else $error("left low carrier before its falling edge");
  AST_RSV_SRC:
    assert property (@(posedge i_clk) disable iff (i_rst)
      src_q > smu_pkg::MSRC_SDO |-> !modv)
    else $error("reserved modulator code not low");
  AST_SW_BIT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      src_q == smu_pkg::MSRC_SW && !stream_active |-> modv == bit_q)
    else $error("software bit not selected");
  AST_KEEP_SEL:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(en_q) |-> $stable(src_q) && $stable(hsel_q) && $stable(lsel_q))
    else $error("selections changed when disabled");
  AST_ENABLE_TRACK:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(en_q) && !oinv_q ##0 mix_w[*2] |=> o_modulated_output_pin)
    else $error("enable did not start modulation");
endmodule

/* File: sim/smu_source_model.sv */
// behavioural peripherals and pins that feed the mixer's source inputs
module smu_source_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [14:0] i_level,
  output logic      [14:0] o_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit map: 0 modulator pin, 2..10 peripherals by code, 11 high pin,
  // 12 low pin, 13 fast oscillator, 14 reference clock; bit 1 is unused
  // peripheral outputs change just after the edge, like real ones
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_src <= 15'h0000;
    end else begin
      o_src <= i_level;
    end
  end
endmodule

/* File: sim/smu_signal_mixer_unit_bench.sv */
// self-checking bench for the signal mixer unit
module smu_signal_mixer_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] lvl;
  logic [14:0] src;
  logic        mod_out;
  logic [31:0] rdat;
  logic        rerr;
  logic        count_en;
  int          n_high;
  int          n_fail;
  int          n_tests;
  int          cycles;
  int          ones;
  int          cb;
  int          t;

  smu_source_model u_smu_source_model (
    .i_clk   (clk),
    .i_rst   (rst),
    .i_level (lvl),
    .o_src   (src)
  );

  smu_signal_mixer_unit u_smu_signal_mixer_unit (
    .i_clk                      (clk),
    .i_rst                      (rst),
    .i_psel                     (psel),
    .i_penable                  (penable),
    .i_pwrite                   (pwrite),
    .i_paddr                    (paddr),
    .i_pwdata                   (pwdata),
    .o_prdata                   (prdata),
    .o_pready                   (pready),
    .o_pslverr                  (pslverr),
    .i_modulator_pin_route      (src[0]),
    .i_high_carrier_pin_route   (src[11]),
    .i_low_carrier_pin_route    (src[12]),
    .i_fast_internal_oscillator (src[13]),
    .i_reference_clock_output   (src[14]),
    .i_capture_compare_one_out  (src[2]),
    .i_capture_compare_two_out  (src[3]),
    .i_pulse_width_three_out    (src[4]),
    .i_pulse_width_four_out     (src[5]),
    .i_comparator_one_out       (src[6]),
    .i_comparator_two_out       (src[7]),
    .i_async_serial_port_rx     (src[8]),
    .i_async_serial_port_tx     (src[9]),
    .i_sync_serial_port_sdo     (src[10]),
    .o_modulated_output_pin     (mod_out)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (count_en && mod_out === 1'b1) begin
      n_high <= n_high + 1;
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // entered right after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    rdat = prdata;
    rerr = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // sources are static, so a few cycles cover mix, sync and output latency
  task automatic see(input logic e, input string nm);
    repeat (8) @(posedge clk);
    chk(nm, {31'h0, e}, {31'h0, mod_out});
    apb(1'b0, smu_pkg::IDX_CON0, 32'h0);
    chk("output status bit", {31'h0, e}, {31'h0, rdat[5]});
  endtask

  task automatic cfg(input logic [31:0] c1, input logic [31:0] c0,
                     input logic e);
    apb(1'b1, smu_pkg::IDX_CON1, c1);
    apb(1'b1, smu_pkg::IDX_CON0, c0);
    see(e, "mixed output");
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    lvl = 15'h0000;
    count_en = 1'b0;
    n_high = 0;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    ones = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, smu_pkg::IDX_CON0 + 14'(i), 32'h0);
      chk("reset value", 32'h0, rdat);
    end
    apb(1'b0, 14'h0F50, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, smu_pkg::IDX_CON0, 32'h0000_0020);
    see(1'b0, "status bit write");
    // high carrier pin at 1, low pin at 0, so output equals modulator
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, smu_pkg::IDX_SRC, 32'(k));
      for (int v = 0; v < 2; v++) begin
        apb(1'b1, smu_pkg::IDX_CON0, 32'h80 | 32'(v));
        lvl <= ((v != 0 ? 15'h1 << k : ~(15'h1 << k)) & 15'h07FF) | 15'h0800;
        see(k < 11 ? v[0] : 1'b0, "modulator source");
      end
    end
    apb(1'b1, smu_pkg::IDX_SRC, 32'h1);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, smu_pkg::IDX_CON0, s != 0 ? 32'h80 : 32'h81);
        apb(1'b1, smu_pkg::IDX_HCAR, s != 0 ? 32'h0 : 32'(c));
        apb(1'b1, smu_pkg::IDX_LCAR, s != 0 ? 32'(c) : 32'h0);
        if (c == 1) begin
          lvl <= 15'h0000;
          repeat (8) @(posedge clk);
          n_high = 0;
          count_en <= 1'b1;
          repeat (40) @(posedge clk);
          count_en <= 1'b0;
          @(posedge clk);
          chk("system clock carrier", 32'd20, n_high);
        end else begin
          cb = (c == 0) ? (s != 0 ? 12 : 11) : (c < 4) ? c + 11 : c - 2;
          for (int v = 0; v < 2; v++) begin
            lvl <= v != 0 ? 15'h1 << cb : ~(15'h1 << cb);
            see(v[0], "carrier source");
          end
        end
      end
    end
    apb(1'b1, smu_pkg::IDX_HCAR, 32'h0);
    apb(1'b1, smu_pkg::IDX_LCAR, 32'h0);
    lvl <= 15'h1800;
    cfg(32'h00, 32'h81, 1'b1);
    cfg(32'h20, 32'h81, 1'b0);
    cfg(32'h00, 32'h80, 1'b1);
    cfg(32'h02, 32'h80, 1'b0);
    cfg(32'h02, 32'h90, 1'b1);
    cfg(32'h02, 32'h10, 1'b0);
    // retained selections across a disable
    apb(1'b1, smu_pkg::IDX_HCAR, 32'h4);
    apb(1'b1, smu_pkg::IDX_LCAR, 32'h5);
    lvl <= 15'h0004;
    cfg(32'h00, 32'h81, 1'b1);
    cfg(32'h00, 32'h01, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, smu_pkg::IDX_SRC + 14'(i), 32'h0);
      chk("kept selection", i == 0 ? 32'h1 : 32'(6 - i), rdat);
    end
    cfg(32'h00, 32'h81, 1'b1);
    apb(1'b1, smu_pkg::IDX_HCAR, 32'h0);
    apb(1'b1, smu_pkg::IDX_LCAR, 32'h0);
    lvl <= 15'h0800;
    cfg(32'h10, 32'h81, 1'b1);
    cfg(32'h10, 32'h80, 1'b1);
    lvl <= 15'h0000;
    see(1'b0, "high sync edge");
    lvl <= 15'h0800;
    see(1'b0, "switched to low");
    lvl <= 15'h1000;
    cfg(32'h01, 32'h80, 1'b1);
    cfg(32'h01, 32'h81, 1'b1);
    lvl <= 15'h0000;
    see(1'b0, "low sync edge");
    lvl <= 15'h1000;
    see(1'b0, "switched to high");
    // stream: fill while disabled, then one write that must wait for a pop
    apb(1'b1, smu_pkg::IDX_CON1, 32'h0);
    apb(1'b1, smu_pkg::IDX_RATE, 32'h3);
    apb(1'b1, smu_pkg::IDX_CON0, 32'h0);
    lvl <= 15'h0800;
    for (int i = 0; i < 17; i++) begin
      if (i == 16) begin
        apb(1'b0, smu_pkg::IDX_STREAM, 32'h0);
        chk("fifo level", 32'd16, {27'h0, rdat[4:0]});
        n_high = 0;
        count_en <= 1'b1;
        apb(1'b1, smu_pkg::IDX_CON0, 32'h80);
      end
      apb(1'b1, smu_pkg::IDX_STREAM, 32'(8'(i * 37 + 1)));
      ones += $countones(8'(i * 37 + 1));
    end
    t = 0;
    do begin
      apb(1'b0, smu_pkg::IDX_STREAM, 32'h0);
      t++;
    end while (rdat[8:0] !== 9'h0 && t < 400);
    repeat (8) @(posedge clk);
    count_en <= 1'b0;
    chk("stream high cycles", 32'(ones * 4), n_high);
    print_verdict();
  end
endmodule
